// File: rtl/comparator_event_logic.sv
// register, flag, interrupt and pin logic of two analog comparators
// assumes the analog macro and the core's power state share clk_sys
// Functional notes
// - set change flag on every output edge
// - request needs flag, local and global enable
// - change flag readable at all times
// - comparators keep running in Idle/Power Down
// - enabled change in low power wakes processor
// - flag stays set; software clears it
// - flag at bit 0, cleared by writing zero
// - value 24h: on, input A, external ref, pin
// - positive input A or B, shared negative pin
// - internal reference selectable instead of pin
// - first result to P0.6, second to P0.0
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module comparator_event_logic #(
   parameter int SETTLE_CYCLES = cmp_evt_pkg::STARTUP_CYCLES
) (
   input  wire logic        clk_sys,       // system clock
   input  wire logic        sys_rst,       // synchronous reset, high
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write strobes
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [7:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   // analog side
   input  wire logic [1:0]  rawResult,     // comparator results, async
   output logic [1:0]       cmpEnable,     // comparator power on
   output logic [1:0]       posSelB,       // positive input: 0 A, 1 B
   output logic [1:0]       refInternal,   // negative: 0 ref pin, 1 internal
   // pins
   output logic             port0Bit6Out,  // first comparator output
   output logic             port0Bit6Oe,   // drive enable of P0.6
   output logic             port0Bit0Out,  // second comparator output
   output logic             port0Bit0Oe,   // drive enable of P0.0
   // core side
   input  wire logic        lowPower,      // core in idle or power down
   output logic [1:0]       cmpIrqReq,     // per comparator request
   output logic             wakeReq,       // wake the core
   output logic             irq            // unmasked event pending
);
   localparam int N = cmp_evt_pkg::NUM_CMP;

   cmp_evt_pkg::cmp_cfg_s   cfg_q [N];
   cmp_evt_pkg::cmp_cfg_s   cfg_d [N];
   cmp_evt_pkg::pin_drive_s pin_q [N];
   cmp_evt_pkg::pin_drive_s pin_d [N];
   logic [N-1:0] flag_q, flag_d;
   logic [N-1:0] level, change, settled;
   logic         globalEn_q, globalEn_d;
   logic [N-1:0] chanEn_q, chanEn_d;
   logic [N-1:0] evtStatus_q, evtStatus_d;
   logic [N-1:0] evtMask_q, evtMask_d;
   logic [N-1:0] irqReq_q, irqReq_d;
   logic         wake_q, wake_d, irq_q, irq_d;

   // bus state
   logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [7:0]  awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic        wByte0_q, wByte0_d;
   logic        awready_q, awready_d, wready_q, wready_d;
   logic        bvalid_q, bvalid_d, arready_q, arready_d;
   logic        rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic        wrEn, wrHit, wrByte;
   logic [7:0]  wrVal;
   logic [7:0]  rdVal;
   logic        rdHit;

   // per comparator datapath
   for (genvar i = 0; i < N; i++) begin : g_chan
      cmp_channel #(
         .SETTLE_CYCLES(SETTLE_CYCLES)
      ) u_chan (
         .clk_sys  (clk_sys),
         .sys_rst  (sys_rst),
         .enable   (cfg_q[i].enable),
         .rawResult(rawResult[i]),
         .level    (level[i]),
         .change   (change[i]),
         .settled  (settled[i])
      );
      assign cmpEnable[i]   = cfg_q[i].enable;
      assign posSelB[i]     = cfg_q[i].posSelB;
      assign refInternal[i] = cfg_q[i].refInternal;
   end

   function automatic logic [7:0] cfgByte(cmp_evt_pkg::cmp_cfg_s c, logic res,
                                          logic flg);
      logic [7:0] b;
      b = 8'h00;
      b[cmp_evt_pkg::CFG_EN_BIT]     = c.enable;
      b[cmp_evt_pkg::CFG_POS_BIT]    = c.posSelB;
      b[cmp_evt_pkg::CFG_REF_BIT]    = c.refInternal;
      b[cmp_evt_pkg::CFG_OE_BIT]     = c.outEnable;
      b[cmp_evt_pkg::CFG_RESULT_BIT] = res;
      b[cmp_evt_pkg::CFG_FLAG_BIT]   = flg;
      return b;
   endfunction : cfgByte

   // write channel
   always_comb begin
      awHeld_d = awHeld_q;
      awAddr_d = awAddr_q;
      wHeld_d  = wHeld_q;
      wData_d  = wData_q;
      wByte0_d = wByte0_q;
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      if (s_axi_awvalid && awready_q) begin
         awHeld_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         wHeld_d  = 1'b1;
         wData_d  = s_axi_wdata;
         wByte0_d = s_axi_wstrb[0];
      end
      wrEn  = awHeld_q && wHeld_q && !bvalid_q;
      wrVal = wData_q[7:0];
      unique case (awAddr_q)
         cmp_evt_pkg::OFF_CFG_FIRST, cmp_evt_pkg::OFF_CFG_SECOND,
         cmp_evt_pkg::OFF_IEN_FIRST, cmp_evt_pkg::OFF_IEN_SECOND,
         cmp_evt_pkg::OFF_EVT_STATUS, cmp_evt_pkg::OFF_EVT_MASK,
         cmp_evt_pkg::OFF_PIN_STATUS: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
      wrByte = wrEn && wrHit && wByte0_q;
      if (wrEn) begin
         awHeld_d = 1'b0;
         wHeld_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = wrHit ? cmp_evt_pkg::RESP_OKAY : cmp_evt_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      awready_d = !awHeld_d && !bvalid_d;
      wready_d  = !wHeld_d && !bvalid_d;
   end

   // read channel
   always_comb begin
      rdHit = 1'b1;
      unique case (s_axi_araddr)
         cmp_evt_pkg::OFF_CFG_FIRST:
            rdVal = cfgByte(cfg_q[0], level[0], flag_q[0]);
         cmp_evt_pkg::OFF_CFG_SECOND:
            rdVal = cfgByte(cfg_q[1], level[1], flag_q[1]);
         cmp_evt_pkg::OFF_IEN_FIRST:
            rdVal = {globalEn_q, 7'h00};
         cmp_evt_pkg::OFF_IEN_SECOND:
            rdVal = {6'h00, chanEn_q};
         cmp_evt_pkg::OFF_EVT_STATUS:
            rdVal = {6'h00, evtStatus_q};
         cmp_evt_pkg::OFF_EVT_MASK:
            rdVal = {6'h00, evtMask_q};
         cmp_evt_pkg::OFF_PIN_STATUS:
            rdVal = {2'h0, settled, 2'h0, level};
         default: begin
            rdVal = 8'h00;
            rdHit = 1'b0;
         end
      endcase
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rdata_d  = {24'h000000, rdVal};
         rresp_d  = rdHit ? cmp_evt_pkg::RESP_OKAY : cmp_evt_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      arready_d = !rvalid_d;
   end

   // configuration, flags, enables and events
   always_comb begin
      globalEn_d  = globalEn_q;
      chanEn_d    = chanEn_q;
      evtMask_d   = evtMask_q;
      evtStatus_d = evtStatus_q;
      if (wrByte && awAddr_q == cmp_evt_pkg::OFF_IEN_FIRST) begin
         globalEn_d = wrVal[cmp_evt_pkg::GLOBAL_EN_BIT];
      end
      if (wrByte && awAddr_q == cmp_evt_pkg::OFF_IEN_SECOND) begin
         chanEn_d = wrVal[cmp_evt_pkg::CHAN_EN_BIT0 +: N];
      end
      if (wrByte && awAddr_q == cmp_evt_pkg::OFF_EVT_MASK) begin
         evtMask_d = wrVal[N-1:0];
      end
      if (wrByte && awAddr_q == cmp_evt_pkg::OFF_EVT_STATUS) begin
         evtStatus_d = evtStatus_q & ~wrVal[N-1:0];
      end
      evtStatus_d = evtStatus_d | change; // set wins over clear
      for (int i = 0; i < N; i++) begin
         cfg_d[i]  = cfg_q[i];
         flag_d[i] = flag_q[i];
         if (wrByte && awAddr_q == (i == 0 ? cmp_evt_pkg::OFF_CFG_FIRST
                                           : cmp_evt_pkg::OFF_CFG_SECOND)) begin
            cfg_d[i].enable      = wrVal[cmp_evt_pkg::CFG_EN_BIT];
            cfg_d[i].posSelB     = wrVal[cmp_evt_pkg::CFG_POS_BIT];
            cfg_d[i].refInternal = wrVal[cmp_evt_pkg::CFG_REF_BIT];
            cfg_d[i].outEnable   = wrVal[cmp_evt_pkg::CFG_OE_BIT];
            flag_d[i]            = wrVal[cmp_evt_pkg::CFG_FLAG_BIT];
         end
         // edge sets the flag even during a clearing write
         flag_d[i] = flag_d[i] | change[i];
         pin_d[i].pinOut = cfg_d[i].outEnable & level[i];
         pin_d[i].pinOe  = cfg_d[i].enable & cfg_d[i].outEnable;
      end
      irqReq_d = flag_d & chanEn_d & {N{globalEn_d}};
      wake_d   = lowPower && (|irqReq_d);
      irq_d    = |(evtStatus_d & evtMask_d);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         awHeld_q    <= 1'b0;
         awAddr_q    <= 8'h00;
         wHeld_q     <= 1'b0;
         wData_q     <= 32'h00000000;
         wByte0_q    <= 1'b0;
         awready_q   <= 1'b0;
         wready_q    <= 1'b0;
         bvalid_q    <= 1'b0;
         bresp_q     <= cmp_evt_pkg::RESP_OKAY;
         arready_q   <= 1'b0;
         rvalid_q    <= 1'b0;
         rdata_q     <= 32'h00000000;
         rresp_q     <= cmp_evt_pkg::RESP_OKAY;
         globalEn_q  <= cmp_evt_pkg::IEN_RESET[cmp_evt_pkg::GLOBAL_EN_BIT];
         chanEn_q    <= cmp_evt_pkg::IEN_RESET[N-1:0];
         evtStatus_q <= cmp_evt_pkg::EVT_RESET;
         evtMask_q   <= cmp_evt_pkg::EVT_RESET;
         irqReq_q    <= '0;
         wake_q      <= 1'b0;
         irq_q       <= 1'b0;
         for (int i = 0; i < N; i++) begin
            cfg_q[i]  <= '0;
            flag_q[i] <= cmp_evt_pkg::CFG_RESET[cmp_evt_pkg::CFG_FLAG_BIT];
            pin_q[i]  <= '0;
         end
      end else begin
         awHeld_q    <= awHeld_d;
         awAddr_q    <= awAddr_d;
         wHeld_q     <= wHeld_d;
         wData_q     <= wData_d;
         wByte0_q    <= wByte0_d;
         awready_q   <= awready_d;
         wready_q    <= wready_d;
         bvalid_q    <= bvalid_d;
         bresp_q     <= bresp_d;
         arready_q   <= arready_d;
         rvalid_q    <= rvalid_d;
         rdata_q     <= rdata_d;
         rresp_q     <= rresp_d;
         globalEn_q  <= globalEn_d;
         chanEn_q    <= chanEn_d;
         evtStatus_q <= evtStatus_d;
         evtMask_q   <= evtMask_d;
         irqReq_q    <= irqReq_d;
         wake_q      <= wake_d;
         irq_q       <= irq_d;
         for (int i = 0; i < N; i++) begin
            cfg_q[i]  <= cfg_d[i];
            flag_q[i] <= flag_d[i];
            pin_q[i]  <= pin_d[i];
         end
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign port0Bit6Out  = pin_q[0].pinOut;
   assign port0Bit6Oe   = pin_q[0].pinOe;
   assign port0Bit0Out  = pin_q[1].pinOut;
   assign port0Bit0Oe   = pin_q[1].pinOe;
   assign cmpIrqReq     = irqReq_q;
   assign wakeReq       = wake_q;
   assign irq           = irq_q;

endmodule : comparator_event_logic

// File: rtl/cmp_evt_pkg.sv
// constants, field layout and carrier types for the comparator event logic
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port
package cmp_evt_pkg;

   localparam int NUM_CMP = 2;
   localparam int ADDR_W  = 8;

   // register byte offsets
   localparam logic [7:0] OFF_CFG_FIRST   = 8'h00;
   localparam logic [7:0] OFF_CFG_SECOND  = 8'h04;
   localparam logic [7:0] OFF_IEN_FIRST   = 8'h08;
   localparam logic [7:0] OFF_IEN_SECOND  = 8'h0c;
   localparam logic [7:0] OFF_EVT_STATUS  = 8'h10;
   localparam logic [7:0] OFF_EVT_MASK    = 8'h14;
   localparam logic [7:0] OFF_PIN_STATUS  = 8'h18;

   // comparator configuration register fields
   localparam int CFG_FLAG_BIT   = 0;
   localparam int CFG_RESULT_BIT = 1;
   localparam int CFG_OE_BIT     = 2;
   localparam int CFG_REF_BIT    = 3;
   localparam int CFG_POS_BIT    = 4;
   localparam int CFG_EN_BIT     = 5;

   // interrupt enable fields
   localparam int GLOBAL_EN_BIT  = 7;
   localparam int CHAN_EN_BIT0   = 0;

   // pin status fields: result levels at 0, settled flags at this base
   localparam int SETTLED_BIT0   = 4;

   // reset values
   localparam logic [7:0] CFG_RESET  = 8'h00;
   localparam logic [7:0] IEN_RESET  = 8'h00;
   localparam logic [1:0] EVT_RESET  = 2'h0;

   // start-up time of a comparator after switch-on
   localparam int STARTUP_NS     = 10000;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic enable;
      logic posSelB;
      logic refInternal;
      logic outEnable;
   } cmp_cfg_s;

   typedef struct packed {
      logic pinOut;
      logic pinOe;
   } pin_drive_s;

endpackage : cmp_evt_pkg

// File: rtl/cmp_channel.sv
// one comparator channel: result synchroniser, change detect, settle timer
// assumes rawResult comes asynchronously from the analog comparator
`timescale 1ns/1ps
module cmp_channel #(
   parameter int SETTLE_CYCLES = cmp_evt_pkg::STARTUP_CYCLES
) (
   input  wire logic clk_sys,    // system clock
   input  wire logic sys_rst,    // synchronous reset, high
   input  wire logic enable,     // comparator switched on
   input  wire logic rawResult,  // analog comparator result
   output logic      level,      // synchronised result
   output logic      change,     // one-cycle pulse per edge
   output logic      settled     // start-up time elapsed
);
   localparam int CW = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CW-1:0] SETTLE_MAX = CW'(SETTLE_CYCLES);

   logic          sync1_q, sync2_q, prev_q, change_q, settled_q;
   logic          prev_d, change_d, settled_d;
   logic [CW-1:0] cnt_q, cnt_d;

   always_comb begin
      // edge found by comparing with the previous level
      change_d = enable && (sync2_q != prev_q);
      prev_d   = sync2_q;
      if (!enable) begin
         cnt_d = '0;
      end else if (cnt_q != SETTLE_MAX) begin
         cnt_d = cnt_q + CW'(1);
      end else begin
         cnt_d = cnt_q;
      end
      settled_d = enable && (cnt_d == SETTLE_MAX);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sync1_q   <= 1'b0;
         sync2_q   <= 1'b0;
         prev_q    <= 1'b0;
         change_q  <= 1'b0;
         settled_q <= 1'b0;
         cnt_q     <= '0;
      end else begin
         sync1_q   <= rawResult;
         sync2_q   <= sync1_q;
         prev_q    <= prev_d;
         change_q  <= change_d;
         settled_q <= settled_d;
         cnt_q     <= cnt_d;
      end
   end

   assign level   = prev_q;
   assign change  = change_q;
   assign settled = settled_q;

endmodule : cmp_channel

// File: dv/comparator_event_logic_properties.sv
// port-level assertions for the comparator event logic
// assumes binding into comparator_event_logic, one clock domain
`timescale 1ns/1ps
module comparator_event_logic_properties #(
   parameter int SETTLE_CYCLES = 8
) (
   input wire logic        clk_sys,       // clock
   input wire logic        sys_rst,       // reset
   input wire logic        s_axi_awvalid, // aw valid
   input wire logic        s_axi_awready, // aw ready
   input wire logic        s_axi_wvalid,  // w valid
   input wire logic        s_axi_wready,  // w ready
   input wire logic [1:0]  s_axi_bresp,   // b resp
   input wire logic        s_axi_bvalid,  // b valid
   input wire logic        s_axi_bready,  // b ready
   input wire logic        s_axi_arvalid, // ar valid
   input wire logic        s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata,   // r data
   input wire logic        s_axi_rvalid,  // r valid
   input wire logic        s_axi_rready,  // r ready
   input wire logic [1:0]  rawResult,     // analog results
   input wire logic        port0Bit6Out,  // first pin
   input wire logic        port0Bit0Out,  // second pin
   input wire logic        lowPower,      // core asleep
   input wire logic [1:0]  cmpIrqReq,     // requests
   input wire logic        wakeReq        // wake
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence rawQuietFirst;
      $stable(rawResult[0]) [*5];
   endsequence
   sequence rawQuietSecond;
      $stable(rawResult[1]) [*5];
   endsequence

   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_wake_needs_sleep: assert property (wakeReq |-> $past(lowPower))
      else $error("wake without low power");
   a_request_wakes: assert property (lowPower && (|cmpIrqReq) |=> wakeReq)
      else $error("request in low power did not wake");
   a_pin_first_level: assert property (rawQuietFirst ##0 port0Bit6Out |-> rawResult[0])
      else $error("first pin disagrees with result");
   a_pin_second_level: assert property (rawQuietSecond ##0 port0Bit0Out |-> rawResult[1])
      else $error("second pin disagrees with result");
endmodule : comparator_event_logic_properties

bind comparator_event_logic comparator_event_logic_properties #(
   .SETTLE_CYCLES(SETTLE_CYCLES)
) u_props (
   .clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rawResult, .port0Bit6Out,
   .port0Bit0Out, .lowPower, .cmpIrqReq, .wakeReq
);

// File: dv/core_model.sv
// processor core power model: sleeps on command, wakes on request
// assumes wakeReq is a level from the comparator block
`timescale 1ns/1ps
module core_model (
   input  wire logic clk_sys,   // clock
   input  wire logic sys_rst,   // reset
   input  wire logic sleepCmd,  // software enters low power
   input  wire logic wakeReq,   // wake request
   output logic      lowPower,  // core asleep
   output int        wakeCount  // wakeups taken
);
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         lowPower  <= 1'b0;
         wakeCount <= 0;
      end else if (lowPower && wakeReq) begin
         lowPower  <= 1'b0;
         wakeCount <= wakeCount + 1;
      end else if (sleepCmd) begin
         lowPower <= 1'b1;
      end
   end
endmodule : core_model

// File: dv/comparator_event_logic_tb.sv
// self-checking bench: register tasks over axi4-lite, analog edges
// assumes the package and design are compiled first
`timescale 1ns/1ps
module comparator_event_logic_tb;
   localparam int SETTLE = 8;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, sleepCmd = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r, cmpEnable, posSelB, refInternal, cmpIrqReq;
   logic [1:0]  rawResult = 2'h0;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        port0Bit6Out, port0Bit6Oe, port0Bit0Out, port0Bit0Oe, lowPower, wakeReq, irq;
   int          wakeCount, failures = 0, checks = 0;

   always #5 clk_sys = ~clk_sys;

   comparator_event_logic #(.SETTLE_CYCLES(SETTLE)) u_comparator_event_logic (
      .clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rawResult, .cmpEnable, .posSelB,
      .refInternal, .port0Bit6Out, .port0Bit6Oe, .port0Bit0Out, .port0Bit0Oe,
      .lowPower, .cmpIrqReq, .wakeReq, .irq);
   core_model u_core_model (.clk_sys, .sys_rst, .sleepCmd, .wakeReq, .lowPower, .wakeCount);

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic waitc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : waitc
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      s_axi_awaddr <= a; s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("write response", 32'(s_axi_bresp), 32'(cmp_evt_pkg::RESP_OKAY));
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata; r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      rd(a);
      chk(nm, d, e);
   endtask : rc
   task automatic tog(input int i);
      @(posedge clk_sys);
      rawResult[i] <= ~rawResult[i];
      waitc(8);
   endtask : tog

   task automatic print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rc(cmp_evt_pkg::OFF_CFG_FIRST, 32'h0, "cfg first reset");
      rc(cmp_evt_pkg::OFF_IEN_FIRST, 32'h0, "ien first reset");
      rd(8'h1c);
      chk("unmapped resp", 32'(r), 32'(cmp_evt_pkg::RESP_SLVERR));
      chk("unmapped data", d, 32'h0);
      wr(cmp_evt_pkg::OFF_CFG_FIRST, 32'h24);
      waitc(SETTLE + 2);
      chk("first setup", {posSelB[0], refInternal[0], cmpEnable[0], port0Bit6Oe}, 4'h3);
      rc(cmp_evt_pkg::OFF_CFG_FIRST, 32'h24, "cfg first on");
      wr(cmp_evt_pkg::OFF_CFG_SECOND, 32'h38);
      waitc(2);
      chk("second select", {posSelB[1], refInternal[1], port0Bit0Oe}, 3'h6);
      wr(cmp_evt_pkg::OFF_CFG_SECOND, 32'h24);
      waitc(SETTLE + 2);
      tog(0);
      rc(cmp_evt_pkg::OFF_CFG_FIRST, 32'h27, "flag on rise");
      chk("first pin", port0Bit6Out, 1'b1);
      tog(0);
      rc(cmp_evt_pkg::OFF_CFG_FIRST, 32'h25, "flag on fall");
      chk("no enables", cmpIrqReq, 2'h0);
      wr(cmp_evt_pkg::OFF_IEN_SECOND, 32'h3);
      waitc(3);
      chk("no global", cmpIrqReq, 2'h0);
      wr(cmp_evt_pkg::OFF_IEN_FIRST, 32'h80);
      waitc(3);
      chk("request", cmpIrqReq, 2'h1);
      // lane 0 strobe low: the write must leave the register alone
      s_axi_wstrb <= 4'h0;
      wr(cmp_evt_pkg::OFF_IEN_FIRST, 32'h0);
      s_axi_wstrb <= 4'h1;
      rc(cmp_evt_pkg::OFF_IEN_FIRST, 32'h80, "strobe off write");
      rc(cmp_evt_pkg::OFF_CFG_FIRST, 32'h25, "flag kept");
      wr(cmp_evt_pkg::OFF_CFG_FIRST, 32'h24);
      rc(cmp_evt_pkg::OFF_CFG_FIRST, 32'h24, "flag cleared");
      waitc(3);
      chk("request gone", cmpIrqReq, 2'h0);
      @(posedge clk_sys);
      sleepCmd <= 1'b1;
      @(posedge clk_sys);
      sleepCmd <= 1'b0;
      waitc(2);
      chk("pin driven asleep", {lowPower, port0Bit6Oe}, 2'h3);
      tog(0);
      chk("wakeups", wakeCount, 32'h1);
      rc(cmp_evt_pkg::OFF_CFG_FIRST, 32'h27, "flag in sleep");
      wr(cmp_evt_pkg::OFF_CFG_FIRST, 32'h24);
      tog(1);
      chk("second pin", port0Bit0Out, 1'b1);
      rc(cmp_evt_pkg::OFF_CFG_SECOND, 32'h27, "second flag");
      chk("second request", cmpIrqReq, 2'h2);
      rc(cmp_evt_pkg::OFF_PIN_STATUS, 32'h33, "pin status");
      chk("irq masked", irq, 1'b0);
      wr(cmp_evt_pkg::OFF_EVT_MASK, 32'h2);
      waitc(2);
      chk("irq raised", irq, 1'b1);
      wr(cmp_evt_pkg::OFF_EVT_STATUS, 32'h2);
      waitc(2);
      chk("irq cleared", irq, 1'b0);
      rc(cmp_evt_pkg::OFF_EVT_STATUS, 32'h1, "event status");
      print_verdict();
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      print_verdict();
   end
endmodule : comparator_event_logic_tb
